// file: tb_top.sv
// Self-checking bench for the touch sensor host access block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [6:0] ADR = 7'h0D;
  localparam logic [7:0] ID = 8'h5A;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [15:0] touch = '0;
  logic [127:0] ksig = {16{8'h40}};
  logic lp = 1'b0;
  logic meas = 1'b0;
  logic [7:0] dl = '0;
  logic [2:0] dpin = '0;
  logic scl, hsda, sda_o, sda_oe, chg_n, cal, sda_w;
  logic [15:0] key_en;
  logic [2:0] dp_o, dp_oe;
  logic [7:0] so;
  logic [7:0] q [8];
  int n_mismatch = 0;
  int num_checks = 0;
  int n_cal = 0;
  int n_on = 0;
  always #4 clock_in = ~clock_in;
  // Pull-up on the data line
  assign sda_w = hsda & ~sda_oe;
  // Calibrate pulses are counted away from the edge that launches them
  always @(negedge clock_in) if (cal === 1'b1) n_cal++;
  tsh_host_bfm i_host (.clk_in(clock_in), .sda_in(sda_w), .scl_out(scl), .sda_out(hsda));
  tsh_host_access #(.SLAVE_ADDR(ADR), .DEVICE_ID(ID)) i_dut (.clock_in(clock_in),
    .arst_n_in(arst_n_in), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .change_n_out(chg_n), .key_touch_in(touch),
    .key_signal_in(ksig), .key_enable_out(key_en), .calibrate_out(cal),
    .low_power_mode_in(lp), .sleep_in(1'b0), .measuring_in(meas),
    .drive_line_in(dl), .dedicated_pin_in(dpin), .dedicated_pin_out(dp_o),
    .dedicated_pin_oe_out(dp_oe), .shared_output_out(so));
  // ==========================================================
  // Tasks
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Sends n data bytes, first byte in the upper half when n is 2
  task automatic wr(input logic [7:0] p, input int n, input logic [15:0] d);
    i_host.start();
    i_host.put({ADR, 1'b0});
    chk(i_host.ack, 1'b0);
    i_host.put(p);
    for (int i = 0; i < n; i++) begin
      i_host.put(d[8*(n-1-i) +: 8]);
    end
    i_host.stop();
  endtask
  task automatic rd(input int n);
    i_host.start();
    i_host.put({ADR, 1'b1});
    for (int i = 0; i < n; i++) begin
      i_host.get(i == n - 1, q[i]);
    end
    i_host.stop();
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    #500000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    step(16);
    arst_n_in = 1'b1;
    step(2);
    chk(chg_n, 1'b0);
    wr(8'h00, 0, 16'h0000);
    rd(2);
    chk(q[0], ID);
    rd(1);
    chk(q[0], ID);
    wr(8'h02, 0, 16'h0000);
    rd(5);
    chk(q[0][7], 1'b1);
    chk(chg_n, 1'b1);
    lp = 1'b1;
    dpin = 3'b101;
    step(10);
    wr(8'h06, 0, 16'h0000);
    rd(1);
    chk(q[0], 8'h05);
    lp = 1'b0;
    touch[9] = 1'b1;
    step(20);
    chk(chg_n, 1'b0);
    wr(8'h03, 0, 16'h0000);
    rd(1);
    chk(chg_n, 1'b0);
    wr(8'h02, 0, 16'h0000);
    rd(3);
    chk(q[2], 8'h02);
    chk(chg_n, 1'b1);
    wr(8'h48, 2, 16'h041C);
    step(4);
    chk(dp_oe, 3'b111);
    chk(dp_o, 3'b001);
    rd(2);
    chk({q[0], q[1]}, 16'h041C);
    // Per-key threshold kept inside its recommended band
    wr(8'h30, 1, 16'h000A);
    rd(1);
    chk(q[0], 8'h0A);
    wr(8'h4B, 2, 16'h0400);
    step(40);
    chk(dp_o[0], 1'b1);
    wr(8'h4C, 1, 16'h00FF);
    step(40);
    chk(dp_o[0], 1'b0);
    // Mid level: on for half of one full counter period
    wr(8'h4C, 1, 16'h0080);
    repeat (1024) begin
      step(1);
      if (dp_o[0] === 1'b1) n_on++;
    end
    chk(n_on[15:0], 16'h0200);
    wr(8'h13, 1, 16'h0000);
    chk(key_en, 16'hFFF7);
    wr(8'h07, 1, 16'h0001);
    chk(n_cal[15:0], 16'h0001);
    wr(8'h07, 1, 16'h0000);
    chk(n_cal[15:0], 16'h0001);
    wr(8'h2A, 2, 16'h0101);
    touch[11] = 1'b1;
    step(20);
    touch[10] = 1'b1;
    step(20);
    wr(8'h04, 0, 16'h0000);
    rd(1);
    chk(q[0], 8'h0A);
    // Equal signals would favour key 12; the stronger key 13 must win
    wr(8'h2C, 2, 16'h0202);
    ksig[13*8 +: 8] = 8'h60;
    touch[13:12] = 2'b11;
    step(20);
    wr(8'h04, 0, 16'h0000);
    rd(1);
    chk(q[0], 8'h2A);
    wr(8'h08, 1, 16'h0002);
    touch[1] = 1'b1;
    step(20);
    wr(8'h03, 0, 16'h0000);
    rd(3);
    chk(q[0], 8'h02);
    chk(q[2], 8'h20);
    meas = 1'b1;
    dl = 8'hA5;
    step(3);
    chk(so, 8'hA5);
    meas = 1'b0;
    step(3);
    chk(so, 8'h00);
    i_host.start();
    i_host.put({7'h0E, 1'b0});
    chk(i_host.ack, 1'b1);
    i_host.stop();
    arst_n_in = 1'b0;
    step(2);
    arst_n_in = 1'b1;
    step(2);
    chk(chg_n, 1'b0);
    chk(key_en, 16'hFFFF);
    wr(8'h02, 0, 16'h0000);
    rd(1);
    chk(q[0][7], 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire

// file: tsh_chk.sv
// Port-level assertions for the touch sensor host access block
`timescale 1ns/1ps
`default_nettype none
module tsh_chk (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic change_n_out,
  input wire logic [15:0] key_touch_in,
  input wire logic [15:0] key_enable_out,
  input wire logic calibrate_out,
  input wire logic measuring_in,
  input wire logic [7:0] drive_line_in,
  input wire logic [2:0] dedicated_pin_oe_out,
  input wire logic [7:0] shared_output_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  AST_OPEN_DRAIN: assert property (sda_oe_out |-> !sda_out)
    else $error("data pin driven high");
  AST_DATA_SCL_LOW: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data line moved while clock high");
  AST_RST_CHANGE: assert property ($rose(arst_n_in) |-> !change_n_out [*8])
    else $error("change line not low after reset");
  AST_RST_PINS: assert property ($rose(arst_n_in) |-> key_enable_out == '1
    && dedicated_pin_oe_out == '0 && shared_output_out == '0)
    else $error("reset defaults wrong");
  AST_CHANGE_REL: assert property ($rose(change_n_out) |-> !scl_in)
    else $error("change line released outside a read");
  AST_KEY_CHANGE: assert property ($changed(key_touch_in) && key_enable_out == '1
    |-> ##[1:4] !change_n_out)
    else $error("key change not flagged");
  AST_CAL_PULSE: assert property (calibrate_out |=> !calibrate_out [*2])
    else $error("calibrate not a single pulse");
  AST_MEAS_FOLLOW: assert property (measuring_in && $past(measuring_in)
    |-> shared_output_out == $past(drive_line_in))
    else $error("shared outputs not following drive");
endmodule
bind tsh_host_access tsh_chk i_chk (.clock_in(clock_in), .arst_n_in(arst_n_in),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .change_n_out(change_n_out), .key_touch_in(key_touch_in),
  .key_enable_out(key_enable_out), .calibrate_out(calibrate_out),
  .measuring_in(measuring_in), .drive_line_in(drive_line_in),
  .dedicated_pin_oe_out(dedicated_pin_oe_out), .shared_output_out(shared_output_out));
`default_nettype wire

// file: tsh_host_access.sv
// Touch sensor controller: serial slave access, status, suppression and pins
`timescale 1ns/1ps
`default_nettype none

module tsh_host_access #(
  parameter logic [6:0] SLAVE_ADDR = 7'h0D,
  // Arbitrary identification value
  parameter logic [7:0] DEVICE_ID = 8'h5A
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic change_n_out,
  input wire logic [tsh_pkg::NKEYS-1:0] key_touch_in,
  input wire logic [tsh_pkg::NKEYS*8-1:0] key_signal_in,
  output logic [tsh_pkg::NKEYS-1:0] key_enable_out,
  output logic calibrate_out,
  input wire logic low_power_mode_in,
  input wire logic sleep_in,
  input wire logic measuring_in,
  input wire logic [tsh_pkg::NGPO-1:0] drive_line_in,
  input wire logic [tsh_pkg::NGPIO-1:0] dedicated_pin_in,
  output logic [tsh_pkg::NGPIO-1:0] dedicated_pin_out,
  output logic [tsh_pkg::NGPIO-1:0] dedicated_pin_oe_out,
  output logic [tsh_pkg::NGPO-1:0] shared_output_out
);

  tsh_pkg::tsh_state_t s;
  tsh_pkg::tsh_state_t n;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] sig(input logic [tsh_pkg::NKEYS*8-1:0] v,
                                     input int k);
    sig = v[k*8 +: 8];
  endfunction

  function automatic tsh_pkg::tsh_state_t rst_state();
    tsh_pkg::tsh_state_t r;
    r = '0;
    r.bus = tsh_pkg::TSH_IDLE;
    r.scl_q = 1'b1;
    r.sda_q = 1'b1;
    r.rst_flag = 1'b1;
    r.chg = 5'h01;
    r.key_en = '1;
    for (int k = 0; k < tsh_pkg::NKEYS; k++) begin
      r.mem[32'(tsh_pkg::LOC_BURST) + k] = tsh_pkg::BURST_RST;
    end
    return r;
  endfunction

  // Reset image held as a constant so the asynchronous branch loads no logic
  localparam tsh_pkg::tsh_state_t RST_S = rst_state();

  // ==========================================================
  // Combinational next state
  logic rise, fall, start_c, stop_c;
  logic [tsh_pkg::NKEYS-1:0] en, touch, blocked, sl_mask;
  logic [3:0] sl_n;
  logic [7:0] gen, rd, pwm_lvl, best;
  logic [2:0] best_i;
  logic sl_touch, pwm_on, dir, wr_en;
  logic [4:0] clr, set;
  logic [1:0] gk;
  logic [7:0] keylo_new, keyhi_new;

  always_comb begin
    n = s;
    n.cal = 1'b0;
    n.scl_q = scl_in;
    n.sda_q = sda_in;
    rise = scl_in & ~s.scl_q;
    fall = ~scl_in & s.scl_q;
    start_c = scl_in & s.scl_q & s.sda_q & ~sda_in;
    stop_c = scl_in & s.scl_q & ~s.sda_q & sda_in;
    clr = '0;
    set = '0;
    wr_en = 1'b0;

    // Keys, slider and group suppression
    for (int k = 0; k < tsh_pkg::NKEYS; k++) begin
      en[k] = s.mem[32'(tsh_pkg::LOC_BURST) + k] != 8'h00;
    end
    touch = key_touch_in & en;
    sl_n = s.mem[tsh_pkg::LOC_SLCTL][3:0];
    if (sl_n > tsh_pkg::SLIDER_MAX) begin
      sl_n = tsh_pkg::SLIDER_MAX;
    end
    for (int k = 0; k < tsh_pkg::NKEYS; k++) begin
      sl_mask[k] = (k < 32'(sl_n));
    end
    for (int k = 0; k < tsh_pkg::NKEYS; k++) begin
      blocked[k] = 1'b0;
      gk = s.mem[32'(tsh_pkg::LOC_GROUP) + k][1:0];
      for (int j = 0; j < tsh_pkg::NKEYS; j++) begin
        if (j != k && gk != 2'h0 && !(sl_mask[k] && sl_mask[j]) &&
            s.mem[32'(tsh_pkg::LOC_GROUP) + j][1:0] == gk) begin
          if (s.det[j]) begin
            blocked[k] = 1'b1;
          end
          if (touch[j] && (sig(key_signal_in, j) > sig(key_signal_in, k) ||
              (sig(key_signal_in, j) == sig(key_signal_in, k) && j < k))) begin
            blocked[k] = 1'b1;
          end
        end
      end
      n.det[k] = touch[k] & (s.det[k] | ~blocked[k]);
    end
    n.key_en = en;

    // Slider position from the strongest detecting slider key
    sl_touch = |(n.det & sl_mask);
    best = '0;
    best_i = '0;
    for (int k = 0; k < 8; k++) begin
      if (n.det[k] && sl_mask[k] && sig(key_signal_in, k) >= best) begin
        best = sig(key_signal_in, k);
        best_i = 3'(k);
      end
    end
    if (sl_touch) begin
      n.slpos = {best_i, 5'h00};
    end

    // Pins and PWM
    if (s.pwm_div == 2'(tsh_pkg::PWM_DIV - 1)) begin
      n.pwm_div = '0;
      n.pwm_cnt = s.pwm_cnt + 8'h01;
    end else begin
      n.pwm_div = s.pwm_div + 2'h1;
    end
    pwm_lvl = s.mem[tsh_pkg::LOC_PWM_LVL];
    if (pwm_lvl <= tsh_pkg::PWM_ON_MAX) begin
      pwm_on = 1'b1;
    end else if (pwm_lvl >= tsh_pkg::PWM_OFF_MIN) begin
      pwm_on = 1'b0;
    end else begin
      pwm_on = s.pwm_cnt >= pwm_lvl;
    end
    for (int i = 0; i < tsh_pkg::NGPIO; i++) begin
      dir = s.mem[tsh_pkg::LOC_GPIO_DIR][tsh_pkg::GPIO_LSB + i];
      n.gp_oe[i] = dir;
      if (s.mem[tsh_pkg::LOC_GPIO_PWM][tsh_pkg::GPIO_LSB + i]) begin
        n.gp_out[i] = pwm_on;
      end else begin
        n.gp_out[i] = s.mem[tsh_pkg::LOC_GPIO_DRV][tsh_pkg::GPIO_LSB + i];
      end
      if (!dir && (low_power_mode_in ||
          (sleep_in && s.mem[tsh_pkg::LOC_WAKE][tsh_pkg::GPIO_LSB + i]))) begin
        n.gpin[i] = dedicated_pin_in[i];
      end
    end
    for (int i = 0; i < tsh_pkg::NGPO; i++) begin
      if (measuring_in) begin
        n.shared_output[i] = drive_line_in[i];
      end else if (s.mem[tsh_pkg::LOC_GPO_PWM][i]) begin
        n.shared_output[i] = pwm_on;
      end else begin
        n.shared_output[i] = s.mem[tsh_pkg::LOC_GPO_DRV][i];
      end
    end

    // Status bytes and read mux
    gen = '0;
    gen[tsh_pkg::GEN_RST_BIT] = s.rst_flag;
    gen[1] = |(s.det & sl_mask);
    gen[0] = |s.det;
    case (s.ptr)
      tsh_pkg::LOC_ID: rd = DEVICE_ID;
      tsh_pkg::LOC_GEN: rd = gen;
      tsh_pkg::LOC_KEYLO: rd = s.det[7:0];
      tsh_pkg::LOC_KEYHI: rd = s.det[15:8];
      tsh_pkg::LOC_SLPOS: rd = s.slpos;
      tsh_pkg::LOC_GPIN: rd = {5'h00, s.gpin};
      default: rd = s.ptr[7] ? 8'h00 : s.mem[s.ptr[6:0]];
    endcase

    // Serial slave
    case (s.bus)
      tsh_pkg::TSH_ADDR: begin
        if (rise) begin
          n.sh = {s.sh[6:0], sda_in};
          n.bitcnt = s.bitcnt + 4'h1;
        end else if (fall && s.bitcnt == 4'h8) begin
          n.bitcnt = '0;
          if (s.sh[7:1] == SLAVE_ADDR) begin
            n.sda_oe = 1'b1;
            n.is_read = s.sh[0];
            n.bus = tsh_pkg::TSH_ACK;
          end else begin
            n.bus = tsh_pkg::TSH_IDLE;
          end
        end
      end
      tsh_pkg::TSH_ACK: begin
        if (fall) begin
          n.bitcnt = '0;
          if (s.is_read) begin
            n.sh = rd;
            n.rloc = s.ptr;
            n.sda_oe = ~rd[7];
            n.bitcnt = 4'h1;
            n.bus = tsh_pkg::TSH_RD;
          end else begin
            n.sda_oe = 1'b0;
            n.bus = tsh_pkg::TSH_WR;
          end
        end
      end
      tsh_pkg::TSH_WR: begin
        if (rise) begin
          n.sh = {s.sh[6:0], sda_in};
          n.bitcnt = s.bitcnt + 4'h1;
        end else if (fall && s.bitcnt == 4'h8) begin
          n.sda_oe = 1'b1;
          n.bus = tsh_pkg::TSH_ACK;
          if (!s.got_ptr) begin
            n.got_ptr = 1'b1;
            n.ptr = s.sh;
            n.wptr = s.sh;
          end else begin
            wr_en = ~s.ptr[7] && s.ptr > tsh_pkg::LOC_GPIN;
            n.ptr = s.ptr + 8'h01;
            if (s.ptr == tsh_pkg::LOC_CAL && s.sh != 8'h00) begin
              n.cal = 1'b1;
            end
          end
        end
      end
      tsh_pkg::TSH_RD: begin
        if (fall && s.bitcnt == 4'h8) begin
          n.sda_oe = 1'b0;
          n.ptr = s.ptr + 8'h01;
          n.bus = tsh_pkg::TSH_RACK;
          for (int i = 0; i < 5; i++) begin
            clr[i] = s.rloc == tsh_pkg::LOC_GEN + 8'(i);
          end
          if (s.rloc == tsh_pkg::LOC_GEN) begin
            n.rst_flag = 1'b0;
          end
        end else if (fall) begin
          n.sh = {s.sh[6:0], 1'b0};
          n.sda_oe = ~s.sh[6];
          n.bitcnt = s.bitcnt + 4'h1;
        end
      end
      tsh_pkg::TSH_RACK: begin
        if (rise) begin
          n.bus = sda_in ? tsh_pkg::TSH_IDLE : tsh_pkg::TSH_ACK;
        end
      end
      default: begin
        n.sda_oe = 1'b0;
      end
    endcase
    if (wr_en) begin
      n.mem[s.ptr[6:0]] = s.sh;
    end
    if (start_c) begin
      n.bus = tsh_pkg::TSH_ADDR;
      n.bitcnt = '0;
      n.sda_oe = 1'b0;
      n.got_ptr = 1'b0;
    end else if (stop_c) begin
      n.bus = tsh_pkg::TSH_IDLE;
      n.sda_oe = 1'b0;
      n.ptr = s.wptr;
    end

    // Change tracking per status location
    keylo_new = n.det[7:0];
    keyhi_new = n.det[15:8];
    set[0] = (|n.det != |s.det) || (sl_touch != gen[1]);
    set[1] = keylo_new != s.det[7:0];
    set[2] = keyhi_new != s.det[15:8];
    set[3] = n.slpos != s.slpos;
    set[4] = n.gpin != s.gpin;
    n.chg = (s.chg & ~clr) | set;
    n.change_n = ~|n.chg;
    n.sda_o = 1'b0;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= RST_S;
    end else begin
      s <= n;
    end
  end

  assign sda_out = s.sda_o;
  assign sda_oe_out = s.sda_oe;
  assign change_n_out = s.change_n;
  assign key_enable_out = s.key_en;
  assign calibrate_out = s.cal;
  assign dedicated_pin_out = s.gp_out;
  assign dedicated_pin_oe_out = s.gp_oe;
  assign shared_output_out = s.shared_output;

endmodule

`default_nettype wire

// file: tsh_host_bfm.sv
// Serial bus host model driving the device's clock and data lines
`timescale 1ns/1ps
`default_nettype none
module tsh_host_bfm (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  logic ack;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic start();
    sda_out = 1'b1;
    tick(2);
    scl_out = 1'b1;
    tick(4);
    sda_out = 1'b0;
    tick(4);
    scl_out = 1'b0;
  endtask
  // Stop also ends a pointer-only write
  task automatic stop();
    tick(1);
    sda_out = 1'b0;
    tick(3);
    scl_out = 1'b1;
    tick(4);
    sda_out = 1'b1;
    tick(4);
  endtask
  // Data changes only while the clock is low; released data floats high
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_out = b;
    tick(3);
    scl_out = 1'b1;
    tick(4);
    r = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic put(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// file: tsh_pkg.sv
// Constants and state type for the touch sensor host access block
package tsh_pkg;
  // ==========================================================
  // Sizes
  localparam int NKEYS = 16;
  localparam int NGPO = 8;
  localparam int NGPIO = 3;
  localparam int MEM_DEPTH = 128;
  // ==========================================================
  // Location map
  localparam logic [7:0] LOC_ID = 8'h00;
  localparam logic [7:0] LOC_GEN = 8'h02;
  localparam logic [7:0] LOC_KEYLO = 8'h03;
  localparam logic [7:0] LOC_KEYHI = 8'h04;
  localparam logic [7:0] LOC_SLPOS = 8'h05;
  localparam logic [7:0] LOC_GPIN = 8'h06;
  localparam logic [7:0] LOC_CAL = 8'h07;
  localparam logic [7:0] LOC_SLCTL = 8'h08;
  localparam logic [7:0] LOC_BURST = 8'h10;
  localparam logic [7:0] LOC_GROUP = 8'h20;
  localparam logic [7:0] LOC_GPO_DRV = 8'h47;
  localparam logic [7:0] LOC_GPIO_DRV = 8'h48;
  localparam logic [7:0] LOC_GPIO_DIR = 8'h49;
  localparam logic [7:0] LOC_GPO_PWM = 8'h4A;
  localparam logic [7:0] LOC_GPIO_PWM = 8'h4B;
  localparam logic [7:0] LOC_PWM_LVL = 8'h4C;
  localparam logic [7:0] LOC_WAKE = 8'h4D;
  // ==========================================================
  // Fields and reset values
  localparam int GPIO_LSB = 2;
  localparam int GEN_RST_BIT = 7;
  localparam logic [7:0] BURST_RST = 8'h08;
  localparam logic [3:0] SLIDER_MAX = 4'h8;
  localparam logic [7:0] PWM_ON_MAX = 8'h0A;
  localparam logic [7:0] PWM_OFF_MIN = 8'hFA;
  localparam int PWM_DIV = 4;
  // ==========================================================
  // State
  typedef enum logic [2:0] {
    TSH_IDLE, TSH_ADDR, TSH_ACK, TSH_WR, TSH_RD, TSH_RACK
  } tsh_bus_t;
  typedef struct packed {
    tsh_bus_t bus;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic is_read;
    logic got_ptr;
    logic [7:0] ptr;
    logic [7:0] wptr;
    logic [7:0] rloc;
    logic scl_q;
    logic sda_q;
    logic sda_oe;
    logic sda_o;
    logic [MEM_DEPTH-1:0][7:0] mem;
    logic [NKEYS-1:0] det;
    logic [7:0] slpos;
    logic [NGPIO-1:0] gpin;
    logic rst_flag;
    logic [4:0] chg;
    logic change_n;
    logic [NKEYS-1:0] key_en;
    logic cal;
    logic [NGPIO-1:0] gp_out;
    logic [NGPIO-1:0] gp_oe;
    logic [NGPO-1:0] shared_output;
    logic [7:0] pwm_cnt;
    logic [1:0] pwm_div;
  } tsh_state_t;
endpackage
